// ---- src/itpri_defines.vh ----
// constants for the interval timer host port: port map, command fields, status layout
`ifndef ITPRI_DEFINES_VH
`define ITPRI_DEFINES_VH

// ***************************************************
// port offsets on the two address bits
// ***************************************************
`define ITPRI_ADDR_COUNTER_PICK_BIT_0     2'h0
`define ITPRI_ADDR_COUNTER_PICK_BIT_1     2'h1
`define ITPRI_ADDR_COUNTER_PICK_BIT_2     2'h2
`define ITPRI_ADDR_CTRL     2'h3

// ***************************************************
// control command fields
// ***************************************************
`define ITPRI_SEL_HI        7
`define ITPRI_SEL_LO        6
`define ITPRI_ACC_HI        5
`define ITPRI_ACC_LO        4
`define ITPRI_MODE_HI       3
`define ITPRI_MODE_LO       1
`define ITPRI_BCD_BIT       0
`define ITPRI_SEL_MULTI     2'h3
`define ITPRI_ACC_LATCH     2'h0
`define ITPRI_ACC_LOW       2'h1
`define ITPRI_ACC_HIGH      2'h2
`define ITPRI_ACC_TWO       2'h3
// multiple latch: count bit, status bit, first pick bit
`define ITPRI_ML_CNT_BIT    5
`define ITPRI_ML_ST_BIT     4
`define ITPRI_ML_PICK0      1

// ***************************************************
// status byte and reset values
// ***************************************************
`define ITPRI_ST_OUT_BIT    7
`define ITPRI_ST_NULL_BIT   6
`define ITPRI_CW            16
`define ITPRI_RST_CNT       16'h0000
`define ITPRI_RST_SET       6'h00
`define ITPRI_RST_BYTE      8'h00

`endif

// ---- src/itpri_core.v ----
// one counter core: counter clock edges, gate sampling, down counter
`timescale 1ns/1ps
`default_nettype none
`include "itpri_defines.vh"

module itpri_core (
   input  wire                  clk,
   input  wire                  rst,
   input  wire                  cclk,
   input  wire                  gate,
   input  wire                  bcd,
   input  wire                  load,
   input  wire [`ITPRI_CW-1:0]  load_val,
   input  wire                  count_en,
   output reg  [`ITPRI_CW-1:0]  down_q,
   output reg                   gate_lvl_q,
   output reg                   gate_trig_q,
   output reg                   rise_q,
   output reg                   fall_q
);

   // ***************************************************
   // edge detection
   // ***************************************************
   reg  cclk_q;                              // last counter clock level
   reg  gate_q;                              // last gate level
   reg  edge_q;                              // pending gate rising edge
   wire rise  = cclk & ~cclk_q;              // counter clock rising
   wire fall  = ~cclk & cclk_q;              // counter clock falling
   wire g_up  = gate & ~gate_q;              // gate rising now

   // bcd decrement, 0000 wraps to 9999
   function [`ITPRI_CW-1:0] dec_bcd;
      input [`ITPRI_CW-1:0] v;
      integer k;
      reg     b;
      begin
         dec_bcd = v;
         b = 1'b1;
         for (k = 0; k < 4; k = k + 1) begin
            if (b) begin
               if (v[4*k+:4] == 4'h0) begin
                  dec_bcd[4*k+:4] = 4'h9;
               end else begin
                  dec_bcd[4*k+:4] = v[4*k+:4] - 4'h1;
                  b = 1'b0;
               end
            end
         end
      end
   endfunction

   // ***************************************************
   // gate flip-flop and down counter
   // ***************************************************
   // a gate edge seen in the same cycle as the clock rise still counts
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cclk_q      <= 1'b0;
         gate_q      <= 1'b0;
         edge_q      <= 1'b0;
         gate_lvl_q  <= 1'b0;
         gate_trig_q <= 1'b0;
         rise_q      <= 1'b0;
         fall_q      <= 1'b0;
         down_q      <= `ITPRI_RST_CNT;
      end else begin
         cclk_q <= cclk;
         gate_q <= gate;
         rise_q <= rise;
         fall_q <= fall;
         if (rise) begin
            gate_lvl_q  <= gate;
            gate_trig_q <= edge_q | g_up;
            edge_q      <= 1'b0;
         end else begin
            gate_trig_q <= 1'b0;
            edge_q      <= edge_q | g_up;
         end
         // zero load wraps on first decrement, giving the full range
         if (load) begin
            down_q <= load_val;
         end else if (fall && count_en) begin
            if (bcd) begin
               down_q <= dec_bcd(down_q);
            end else begin
               down_q <= down_q - 16'h0001;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ---- src/itpri_top.v ----
// interval timer host port: port decode, commands, count load and readback
`timescale 1ns/1ps
`default_nettype none
`include "itpri_defines.vh"

module itpri_top #(
   parameter NUM_CTR = 3
) (
   input  wire                        clk,
   input  wire                        rst,
   input  wire                        cs_n,
   input  wire                        rd_n,
   input  wire                        wr_n,
   input  wire [1:0]                  addr,
   input  wire [7:0]                  data_in,
   output reg  [7:0]                  data_out,
   output reg                         data_oe,
   input  wire [NUM_CTR-1:0]          ctr_clk,
   input  wire [NUM_CTR-1:0]          gate_input,
   input  wire [NUM_CTR-1:0]          timer_output,
   input  wire [NUM_CTR-1:0]          count_transfer,
   input  wire [NUM_CTR-1:0]          count_enable,
   output wire [NUM_CTR*16-1:0]       count_reg,
   output wire [NUM_CTR*16-1:0]       down_count,
   output wire [NUM_CTR*3-1:0]        ctr_mode,
   output wire [NUM_CTR-1:0]          ctr_bcd,
   output reg  [NUM_CTR-1:0]          null_count,
   output reg  [NUM_CTR-1:0]          mode_set,
   output reg  [NUM_CTR-1:0]          count_written,
   output reg  [NUM_CTR-1:0]          count_partial,
   output wire [NUM_CTR-1:0]          gate_level,
   output wire [NUM_CTR-1:0]          gate_trigger,
   output wire [NUM_CTR-1:0]          clk_rise,
   output wire [NUM_CTR-1:0]          clk_fall
);

   // ***************************************************
   // strobe decode
   // ***************************************************
   // chip select qualification is done here, on both strobes
   wire       wr_act = ~cs_n & ~wr_n & rd_n;
   wire       rd_act = ~cs_n & ~rd_n & wr_n;   // read strobe active
   reg        wr_act_q;                        // write strobe last cycle
   reg        rd_act_q;                        // read strobe last cycle
   reg  [1:0] rd_addr_q;                       // address of current read
   // writes act once, on the first cycle of the strobe
   wire       wr_ev  = wr_act & ~wr_act_q;
   // read side effects wait for the strobe to end, so data holds
   wire       rd_end = rd_act_q & ~rd_act;

   // ***************************************************
   // control command decode
   // ***************************************************
   wire [1:0] cw_sel  = data_in[`ITPRI_SEL_HI:`ITPRI_SEL_LO];
   wire [1:0] cw_acc  = data_in[`ITPRI_ACC_HI:`ITPRI_ACC_LO];
   wire [2:0] cw_mode = data_in[`ITPRI_MODE_HI:`ITPRI_MODE_LO];
   // control port write
   wire       is_ctl  = wr_ev && (addr == `ITPRI_ADDR_CTRL);
   // multiple latch command
   wire       is_mlc  = is_ctl && (cw_sel == `ITPRI_SEL_MULTI);
   // count latch command for one counter
   wire       is_cl   = is_ctl && (cw_sel != `ITPRI_SEL_MULTI)
                        && (cw_acc == `ITPRI_ACC_LATCH);
   // mode setting command
   wire       is_ms   = is_ctl && (cw_sel != `ITPRI_SEL_MULTI)
                        && (cw_acc != `ITPRI_ACC_LATCH);
   // count byte write to a counter port
   wire       is_cw   = wr_ev && (addr != `ITPRI_ADDR_CTRL);

   // ***************************************************
   // per counter state
   // ***************************************************
   reg  [15:0] cr_q     [0:NUM_CTR-1];   // count register
   reg  [15:0] ol_q     [0:NUM_CTR-1];   // count latch
   reg  [7:0]  st_q     [0:NUM_CTR-1];   // status latch
   reg  [5:0]  set_q    [0:NUM_CTR-1];   // low six bits of mode command
   reg         ol_held_q[0:NUM_CTR-1];   // count latch holds unread value
   reg         st_held_q[0:NUM_CTR-1];   // status latch holds unread value
   reg         wr_hi_q  [0:NUM_CTR-1];   // next count write is high byte
   reg         rd_hi_q  [0:NUM_CTR-1];   // next count read is high byte
   wire [15:0] dn_w     [0:NUM_CTR-1];   // live down counter values

   // ***************************************************
   // counter cores and flattened views
   // ***************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_CTR; g = g + 1) begin : g_ctr
         // count register content, read by the mode logic
         assign count_reg[16*g+:16] = cr_q[g];
         assign dn_w[g]             = down_count[16*g+:16];
         // mode and counting base as last set
         assign ctr_mode[3*g+:3]    = set_q[g][`ITPRI_MODE_HI:`ITPRI_MODE_LO];
         assign ctr_bcd[g]          = set_q[g][`ITPRI_BCD_BIT];
         itpri_core u_core (
            .clk         (clk),
            .rst         (rst),
            .cclk        (ctr_clk[g]),
            .gate        (gate_input[g]),
            .bcd         (set_q[g][`ITPRI_BCD_BIT]),
            .load        (count_transfer[g]),
            .load_val    (cr_q[g]),
            .count_en    (count_enable[g]),
            .down_q      (down_count[16*g+:16]),
            .gate_lvl_q  (gate_level[g]),
            .gate_trig_q (gate_trigger[g]),
            .rise_q      (clk_rise[g]),
            .fall_q      (clk_fall[g])
         );
      end
   endgenerate

   // ***************************************************
   // read data select
   // ***************************************************
   // unlatched reads track the live counter; a moving count can tear
   // between bytes, which is why the host stops the clock or gate
   reg  [15:0] rd_src;    // latched or live count
   reg  [7:0]  rd_byte;   // byte placed on the bus
   reg  [1:0]  rd_acc;    // byte mode of addressed counter
   always @* begin
      rd_src  = 16'h0000;
      rd_byte = `ITPRI_RST_BYTE;
      rd_acc  = `ITPRI_ACC_LATCH;
      if (addr != `ITPRI_ADDR_CTRL) begin
         rd_acc = set_q[addr][`ITPRI_ACC_HI:`ITPRI_ACC_LO];
         // held count wins over live count
         rd_src = ol_held_q[addr] ? ol_q[addr] : dn_w[addr];
         if (st_held_q[addr]) begin
            // status always comes out first
            rd_byte = st_q[addr];
         end else if (rd_acc == `ITPRI_ACC_HIGH) begin
            rd_byte = rd_src[15:8];
         end else if (rd_acc == `ITPRI_ACC_TWO) begin
            rd_byte = rd_hi_q[addr] ? rd_src[15:8] : rd_src[7:0];
         end else begin
            rd_byte = rd_src[7:0];
         end
      end
   end

   // ***************************************************
   // bus output registers
   // ***************************************************
   // the control port is write only, so reads of it leave the bus alone
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_act_q  <= 1'b0;
         rd_act_q  <= 1'b0;
         rd_addr_q <= 2'h0;
         data_out  <= `ITPRI_RST_BYTE;
         data_oe   <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         if (rd_act) begin
            rd_addr_q <= addr;
         end
         data_oe  <= rd_act && (addr != `ITPRI_ADDR_CTRL);
         data_out <= rd_act ? rd_byte : `ITPRI_RST_BYTE;
      end
   end

   // ***************************************************
   // command, count write and read side effects
   // ***************************************************
   // later assignments win, so every set of the null flag lands
   // after its clear and an event in the clearing cycle survives
   integer i;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < NUM_CTR; i = i + 1) begin
            cr_q[i]      <= `ITPRI_RST_CNT;
            ol_q[i]      <= `ITPRI_RST_CNT;
            st_q[i]      <= `ITPRI_RST_BYTE;
            set_q[i]     <= `ITPRI_RST_SET;
            ol_held_q[i] <= 1'b0;
            st_held_q[i] <= 1'b0;
            wr_hi_q[i]   <= 1'b0;
            rd_hi_q[i]   <= 1'b0;
         end
         null_count    <= {NUM_CTR{1'b0}};
         mode_set      <= {NUM_CTR{1'b0}};
         count_written <= {NUM_CTR{1'b0}};
         count_partial <= {NUM_CTR{1'b0}};
      end else begin
         mode_set      <= {NUM_CTR{1'b0}};
         count_written <= {NUM_CTR{1'b0}};
         for (i = 0; i < NUM_CTR; i = i + 1) begin
            // transfer into the down counter validates the count
            if (count_transfer[i]) begin
               null_count[i] <= 1'b0;
            end
            // read completion releases latches and steps byte order
            if (rd_end && (rd_addr_q == i[1:0])) begin
               if (st_held_q[i]) begin
                  st_held_q[i] <= 1'b0;
               end else if (set_q[i][`ITPRI_ACC_HI:`ITPRI_ACC_LO] == `ITPRI_ACC_TWO) begin
                  // order flips only here; a mode command for this counter also clears it
                  rd_hi_q[i] <= ~rd_hi_q[i];
                  if (rd_hi_q[i]) begin
                     ol_held_q[i] <= 1'b0;
                  end
               end else begin
                  ol_held_q[i] <= 1'b0;
               end
            end
            // single counter count latch
            if (is_cl && (cw_sel == i[1:0]) && !ol_held_q[i]) begin
               ol_q[i]      <= dn_w[i];
               ol_held_q[i] <= 1'b1;
            end
            // multiple latch, count part, picked and not held
            if (is_mlc && data_in[`ITPRI_ML_PICK0+i] && !data_in[`ITPRI_ML_CNT_BIT]
                && !ol_held_q[i]) begin
               ol_q[i]      <= dn_w[i];
               ol_held_q[i] <= 1'b1;
            end
            // multiple latch, status part, picked and not held
            if (is_mlc && data_in[`ITPRI_ML_PICK0+i] && !data_in[`ITPRI_ML_ST_BIT]
                && !st_held_q[i]) begin
               st_q[i]      <= {timer_output[i], null_count[i], set_q[i]};
               st_held_q[i] <= 1'b1;
            end
            // mode setting: copy six bits, restart byte order, drop latches
            if (is_ms && (cw_sel == i[1:0])) begin
               set_q[i]         <= data_in[5:0];
               wr_hi_q[i]       <= 1'b0;
               rd_hi_q[i]       <= 1'b0;
               ol_held_q[i]     <= 1'b0;
               st_held_q[i]     <= 1'b0;
               null_count[i]    <= 1'b1;
               mode_set[i]      <= 1'b1;
               count_partial[i] <= 1'b0;
            end
            // count byte write, interpreted only by the stored byte mode;
            // writes before any mode command are dropped
            if (is_cw && (addr == i[1:0])) begin
               case (set_q[i][`ITPRI_ACC_HI:`ITPRI_ACC_LO])
                  `ITPRI_ACC_LOW: begin
                     cr_q[i]          <= {8'h00, data_in};
                     null_count[i]    <= 1'b1;
                     count_written[i] <= 1'b1;
                  end
                  `ITPRI_ACC_HIGH: begin
                     cr_q[i]          <= {data_in, 8'h00};
                     null_count[i]    <= 1'b1;
                     count_written[i] <= 1'b1;
                  end
                  `ITPRI_ACC_TWO: begin
                     if (!wr_hi_q[i]) begin
                        cr_q[i][7:0]     <= data_in;
                        wr_hi_q[i]       <= 1'b1;
                        count_partial[i] <= 1'b1;
                     end else begin
                        cr_q[i][15:8]    <= data_in;
                        wr_hi_q[i]       <= 1'b0;
                        count_partial[i] <= 1'b0;
                        null_count[i]    <= 1'b1;
                        count_written[i] <= 1'b1;
                     end
                  end
                  default: begin
                     cr_q[i] <= cr_q[i];
                  end
               endcase
            end
         end
      end
   end

endmodule
`default_nettype wire

// ---- test/itpri_top_props.sv ----
// concurrent checks on the timer host port, counter 0 side
`timescale 1ns/1ps
`default_nettype none
module itpri_top_props #(
   parameter NUM_CTR = 3
) (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   cs_n,
   input wire logic                   rd_n,
   input wire logic                   wr_n,
   input wire logic [1:0]             addr,
   input wire logic                   data_oe,
   input wire logic [NUM_CTR-1:0]     count_transfer,
   input wire logic [NUM_CTR*16-1:0]  down_count,
   input wire logic [NUM_CTR*3-1:0]   ctr_mode,
   input wire logic [NUM_CTR-1:0]     ctr_bcd,
   input wire logic [NUM_CTR-1:0]     null_count,
   input wire logic [NUM_CTR-1:0]     mode_set,
   input wire logic [NUM_CTR-1:0]     count_written,
   input wire logic [NUM_CTR-1:0]     count_partial,
   input wire logic [NUM_CTR-1:0]     gate_trigger,
   input wire logic [NUM_CTR-1:0]     clk_rise
);
   // *****
   // read strobe as the port decodes it
   // *****
   wire rd_s = !cs_n && !rd_n && wr_n;   // one access kind at a time
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_ctrl_no_drive: assert property (rd_s && addr == 2'h3 |=> !data_oe)
      else $error("control port read drove the bus");
   chk_read_drive: assert property (rd_s && addr != 2'h3 |=> data_oe)
      else $error("counter read left the bus undriven");
   chk_bus_release: assert property (!rd_s |=> !data_oe)
      else $error("bus still driven after the read ended");
   chk_null_on_mode: assert property (mode_set[0] |-> null_count[0])
      else $error("mode command left null flag clear");
   // quiet bus on both sides, so no write can set the flag again
   chk_null_clear: assert property (count_transfer[0] && cs_n && $past(cs_n) ##1 cs_n |-> !null_count[0])
      else $error("transfer did not clear null flag");
   chk_null_on_count: assert property (count_written[0] |-> null_count[0])
      else $error("count write left null flag clear");
   chk_pair_done: assert property (count_written[0] |-> !count_partial[0])
      else $error("pending high byte after completed count");
   chk_mode_hold: assert property ($changed(ctr_mode[2:0]) |-> mode_set[0])
      else $error("mode changed without a mode command");
   // binary steps go down by one, zero wraps to all ones
   chk_dec_step: assert property ($changed(down_count[15:0]) && !ctr_bcd[0] && !count_transfer[0]
      && !$past(count_transfer[0]) && !$past(count_transfer[0], 2)
      |-> down_count[15:0] == $past(down_count[15:0]) - 16'h0001)
      else $error("down counter moved by other than one");
   // a gate edge is only reported on a counter clock rise
   chk_trig_on_rise: assert property (gate_trigger[0] |-> clk_rise[0])
      else $error("gate trigger without counter clock rise");
   cov_mode: cover property (mode_set[0]);
   cov_count: cover property (count_written[0]);
   cov_ctrl_read: cover property (rd_s && addr == 2'h3);
endmodule
bind itpri_top itpri_top_props #(.NUM_CTR(NUM_CTR)) u_props (.clk(clk), .rst(rst), .cs_n(cs_n),
   .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_oe(data_oe), .count_transfer(count_transfer),
   .down_count(down_count), .ctr_mode(ctr_mode), .ctr_bcd(ctr_bcd), .null_count(null_count),
   .mode_set(mode_set), .count_written(count_written), .count_partial(count_partial),
   .gate_trigger(gate_trigger), .clk_rise(clk_rise));
`default_nettype wire

// ---- test/itpri_host_model.sv ----
// host processor model driving the strobed 8-bit port
`timescale 1ns/1ps
`default_nettype none
module itpri_host_model (
   input  wire logic       clk,
   output var  logic       cs_n,
   output var  logic       rd_n,
   output var  logic       wr_n,
   output var  logic [1:0] addr,
   output var  logic [7:0] data_in,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe
);
   // bus idle, data lines show a pattern rather than a held value
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 2'h0;
      data_in = 8'h5A;
   end
   // *****
   // write cycle: strobe held two edges, one idle edge after
   // *****
   task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      addr <= a;
      data_in <= d;
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      data_in <= ~d;   // released lines must not look like held data
      @(posedge clk);
   endtask
   // read cycle: answer taken at the edge before release
   task automatic bus_rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      addr <= a;
      repeat (3) @(posedge clk);
      d = data_out;
      oe = data_oe;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (2) @(posedge clk);   // side effects land at release
   endtask
endmodule
`default_nettype wire

// ---- test/itpri_top_bench.sv ----
// self-checking bench for the timer host port
`timescale 1ns/1ps
`default_nettype none
module itpri_top_bench;
   logic        clk = 1'b0;            // 200 MHz system clock
   logic        rst = 1'b1;            // held for six cycles
   logic        cs_n, rd_n, wr_n;      // host strobes
   logic [1:0]  addr;                  // port select
   logic [7:0]  data_in, data_out, d;  // bus data
   logic        data_oe, oe;           // bus drive flag
   logic [2:0]  ctr_clk = 3'h0;        // counter clocks, stopped between pulses
   logic [2:0]  gate_in = 3'h0;        // gates
   logic [2:0]  t_out = 3'h0;          // output levels from the mode logic
   logic [2:0]  xfer_p = 3'h0;         // count transfer pulses
   logic [2:0]  cnt_en = 3'h1;         // only counter 0 decrements
   wire  [47:0] count_reg, down_count;
   wire  [8:0]  ctr_mode;
   wire  [2:0]  ctr_bcd, null_count, count_partial, gate_level;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cyc = 0;
   always #2.5 clk = ~clk;
   itpri_host_model u_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
   itpri_top #(.NUM_CTR(3)) DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ctr_clk(ctr_clk),
      .gate_input(gate_in), .timer_output(t_out), .count_transfer(xfer_p), .count_enable(cnt_en),
      .count_reg(count_reg), .down_count(down_count), .ctr_mode(ctr_mode), .ctr_bcd(ctr_bcd),
      .null_count(null_count), .mode_set(), .count_written(), .count_partial(count_partial),
      .gate_level(gate_level), .gate_trigger(), .clk_rise(), .clk_fall());
   // *****
   // compare tasks and bus helpers
   // *****
   task chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      u_host.bus_wr(a, v);
   endtask
   // read one byte and check the device drove it
   task rd_chk(input logic [1:0] a, input logic [7:0] exp);
      u_host.bus_rd(a, d, oe);
      chk8(d, exp);
      chk8({7'h0, oe}, 8'h01);
   endtask
   // one counter clock pulse; the falling half steps the count
   task cpulse;
      @(posedge clk) ctr_clk[0] <= 1'b1;
      repeat (3) @(posedge clk);
      ctr_clk[0] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task end_sim;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, far above the roughly 160 cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_sim;
      end
   end
   // *****
   // test sequence
   // *****
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      gate_in <= 3'h1;
      wr(2'h3, 8'h34);
      chk16({13'h0, ctr_mode[2:0]}, 16'h0002);
      chk16({15'h0, null_count[0]}, 16'h0001);
      wr(2'h0, 8'h10);
      chk16({15'h0, count_partial[0]}, 16'h0001);
      wr(2'h0, 8'h27);
      chk16(count_reg[15:0], 16'h2710);
      $display("test two-byte load done");
      wr(2'h3, 8'h50);
      wr(2'h1, 8'hAB);
      chk16(count_reg[31:16], 16'h00AB);
      wr(2'h3, 8'hA1);
      wr(2'h2, 8'h55);
      chk16(count_reg[47:32], 16'h5500);
      chk16({15'h0, ctr_bcd[2]}, 16'h0001);
      $display("test single-byte modes done");
      @(posedge clk) xfer_p[0] <= 1'b1;
      @(posedge clk) xfer_p[0] <= 1'b0;
      repeat (2) @(posedge clk);
      chk16(down_count[15:0], 16'h2710);
      chk16({15'h0, null_count[0]}, 16'h0000);
      wr(2'h3, 8'h00);
      cpulse;
      chk16(down_count[15:0], 16'h270F);
      chk16({15'h0, gate_level[0]}, 16'h0001);
      wr(2'h3, 8'h00);
      cpulse;
      rd_chk(2'h0, 8'h10);
      rd_chk(2'h0, 8'h27);
      rd_chk(2'h0, 8'h0E);
      rd_chk(2'h0, 8'h27);
      $display("test count latch done");
      t_out <= 3'h1;
      wr(2'h3, 8'hC2);
      cpulse;
      t_out <= 3'h0;
      wr(2'h3, 8'hC2);
      cpulse;
      rd_chk(2'h0, 8'hB4);
      rd_chk(2'h0, 8'h0E);
      rd_chk(2'h0, 8'h27);
      rd_chk(2'h0, 8'h0C);
      wr(2'h1, 8'h77);
      rd_chk(2'h0, 8'h27);
      chk16(count_reg[31:16], 16'h0077);
      chk16({13'h0, ctr_mode[2:0]}, 16'h0002);
      $display("test multiple latch done");
      wr(2'h3, 8'hE4);
      rd_chk(2'h1, 8'h50);
      rd_chk(2'h1, 8'h00);
      u_host.bus_rd(2'h3, d, oe);
      chk8({7'h0, oe}, 8'h00);
      $display("test status only and control read done");
      end_sim;
   end
endmodule
`default_nettype wire
